/* design/rmw_pkg.sv */
// package of constants for the rmw bit and block move engine
// Contract
// RL1: writes to unmapped addresses change no storage and are dropped.
// RL2: reads from unmapped addresses return undefined data.
// RL3: block move copies count bytes from source pointer to destination pointer.
// RL4: software keeps destination end at or below top of 24-bit space.
// RL5: bit ops read whole byte, change one bit, write byte back.
// RL6: shared address: read gives running count, write loads reload register.
// RL7: port data read gives pin for inputs, latch for outputs.
// RL8: write-only direction register reads back all ones.
// RL9: direction bit zero makes pin input, one makes it output.
// RL10: software keeps a shadow copy and writes whole byte to port.
package rmw_pkg;
    localparam int          ADDR_W          = 24;
    localparam int          RAM_WORDS       = 256;
    localparam int          RAM_AW          = 8;
    // address map
    localparam logic [23:0] RAM_BASE        = 24'h00_ff00;
    localparam logic [23:0] RAM_TOP         = 24'h00_ffff;
    localparam logic [23:0] ADDR_PORT_DATA  = 24'hff_ffd8;
    localparam logic [23:0] ADDR_PORT_DIR   = 24'hff_ffe8;
    localparam logic [23:0] ADDR_TIMER      = 24'hff_ffb0;
    localparam logic [23:0] ADDR_MAX        = 24'hff_ffff;
    // reset values and fixed read data
    localparam logic [7:0]  LATCH_RST       = 8'h00;
    localparam logic [7:0]  DIR_RST         = 8'h00;
    localparam logic [7:0]  RELOAD_RST      = 8'h00;
    localparam logic [7:0]  ALL_ONES        = 8'hff;
    localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;
    // operation codes
    localparam logic [2:0]  OP_SET          = 3'h0;
    localparam logic [2:0]  OP_CLEAR        = 3'h1;
    localparam logic [2:0]  OP_INVERT       = 3'h2;
    localparam logic [2:0]  OP_STORE        = 3'h3;
    localparam logic [2:0]  OP_STORE_INV    = 3'h4;
    localparam logic [2:0]  OP_MOVE_WORD    = 3'h5;
    localparam logic [2:0]  OP_MOVE_BYTE    = 3'h6;
    localparam logic [2:0]  OP_NONE         = 3'h7;

    typedef enum logic [4:0] {
        RMW_IDLE  = 5'b0_0001,
        RMW_READ  = 5'b0_0010,
        RMW_WRITE = 5'b0_0100,
        RMW_MREAD = 5'b0_1000,
        RMW_MWRIT = 5'b1_0000
    } rmw_state_e;
endpackage

/* design/rmw_mem.sv */
// on-chip bus: ram, port five, reload timer, unmapped decode
`timescale 1ns/1ns
`default_nettype none
module rmw_mem (
    // clock and control
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    // bus
    input  wire logic [23:0] addr_in,
    input  wire logic        wr_in,
    input  wire logic [7:0]  wdata_in,
    output logic      [7:0]  rdata_out,
    // port pins and timer count
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe_out,
    output logic      [7:0]  count_out
);
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] reload;
        logic [7:0] count;
    } rmw_mem_s;

    rmw_mem_s   st;
    rmw_mem_s   next_st;
    logic [7:0] ram [rmw_pkg::RAM_WORDS];
    logic       in_ram;

    assign in_ram = (addr_in >= rmw_pkg::RAM_BASE) && (addr_in <= rmw_pkg::RAM_TOP);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        if (in_ram) begin
            rdata_out = ram[addr_in[rmw_pkg::RAM_AW-1:0]];
        end else if (addr_in == rmw_pkg::ADDR_PORT_DATA) begin
            rdata_out = (st.dir & st.latch) | (~st.dir & pin_in); // [RL7]
        end else if (addr_in == rmw_pkg::ADDR_PORT_DIR) begin
            rdata_out = rmw_pkg::ALL_ONES; // [RL8]
        end else if (addr_in == rmw_pkg::ADDR_TIMER) begin
            rdata_out = st.count; // [RL6]
        end else begin
            rdata_out = rmw_pkg::UNMAPPED_DATA; // [RL2]
        end
    end

    // ------------------------------------------------------------
    // register update
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.count = (st.count == 8'h00) ? st.reload : st.count - 8'h01;
        if (wr_in) begin
            case (addr_in)
                rmw_pkg::ADDR_PORT_DATA: next_st.latch = wdata_in;
                rmw_pkg::ADDR_PORT_DIR:  next_st.dir = wdata_in;
                rmw_pkg::ADDR_TIMER:     next_st.reload = wdata_in; // [RL6]
                default:                 next_st = next_st; // [RL1]
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            st <= '{rmw_pkg::LATCH_RST, rmw_pkg::DIR_RST, rmw_pkg::RELOAD_RST, 8'h00};
        end else if (ce_in) begin
            st <= next_st;
            if (wr_in && in_ram) begin
                ram[addr_in[rmw_pkg::RAM_AW-1:0]] <= wdata_in;
            end
        end
    end

    assign pin_out    = st.latch;
    assign pin_oe_out = st.dir; // [RL9]
    assign count_out  = st.count;
endmodule
`default_nettype wire

/* design/rmw_core.sv */
// cpu bit manipulation and block move engine over the internal bus
`timescale 1ns/1ns
`default_nettype none
module rmw_core (
    // clock and control
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    input  wire logic        ce_in,
    // command
    input  wire logic        start_in,
    input  wire logic [2:0]  op_in,
    input  wire logic [23:0] addr_in,
    input  wire logic [2:0]  bit_in,
    input  wire logic        carry_in,
    input  wire logic [23:0] source_pointer_reg_in,
    input  wire logic [23:0] dest_pointer_reg_in,
    input  wire logic [15:0] count_reg_word_in,
    // status
    output logic             busy_out,
    output logic             done_out,
    output logic      [7:0]  last_data_out,
    output logic      [23:0] source_pointer_reg_out,
    output logic      [23:0] dest_pointer_reg_out,
    output logic      [15:0] count_reg_out,
    // port five pins and timer count
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe_out,
    output logic      [7:0]  count_out
);
    typedef rmw_pkg::rmw_state_e rmw_state_e_t;
    typedef struct packed {
        rmw_state_e_t state;
        logic [2:0]   op;
        logic [2:0]   bitn;
        logic         carry;
        logic [23:0]  addr;
        logic [23:0]  src;
        logic [23:0]  dst;
        logic [15:0]  cnt;
        logic [7:0]   data;
        logic         done;
    } rmw_core_s;

    rmw_core_s   st;
    rmw_core_s   next_st;
    logic [23:0] bus_addr;
    logic        bus_wr;
    logic [7:0]  bus_wdata;
    logic [7:0]  bus_rdata;
    logic [7:0]  mask;
    logic [7:0]  pin_q;
    logic [7:0]  oe_q;
    logic [7:0]  cnt_q;

    rmw_mem u_mem (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .ce_in       (ce_in),
        .addr_in     (bus_addr),
        .wr_in       (bus_wr),
        .wdata_in    (bus_wdata),
        .rdata_out   (bus_rdata),
        .pin_in      (pin_in),
        .pin_out     (pin_q),
        .pin_oe_out  (oe_q),
        .count_out   (cnt_q)
    );

    assign mask = 8'h01 << st.bitn;

    // ------------------------------------------------------------
    // bus drive
    // ------------------------------------------------------------
    always_comb begin
        bus_addr  = st.addr;
        bus_wr    = 1'b0;
        bus_wdata = st.data;
        case (st.state)
            rmw_pkg::RMW_WRITE: bus_wr = 1'b1; // [RL5]
            rmw_pkg::RMW_MREAD: bus_addr = st.src;
            rmw_pkg::RMW_MWRIT: begin
                bus_addr = st.dst;
                bus_wr   = 1'b1;
            end
            default:            bus_wr = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        case (st.state)
            rmw_pkg::RMW_IDLE: begin
                if (start_in) begin
                    next_st.op    = op_in;
                    next_st.bitn  = bit_in;
                    next_st.carry = carry_in;
                    next_st.addr  = addr_in;
                    next_st.src   = source_pointer_reg_in;
                    next_st.dst   = dest_pointer_reg_in;
                    next_st.cnt   = (op_in == rmw_pkg::OP_MOVE_BYTE) ?
                                    {8'h00, count_reg_word_in[7:0]} : count_reg_word_in; // [RL3]
                    if (op_in == rmw_pkg::OP_MOVE_WORD || op_in == rmw_pkg::OP_MOVE_BYTE) begin
                        next_st.state = rmw_pkg::RMW_MREAD;
                    end else if (op_in == rmw_pkg::OP_NONE) begin
                        next_st.done = 1'b1;
                    end else begin
                        next_st.state = rmw_pkg::RMW_READ;
                    end
                end
            end
            rmw_pkg::RMW_READ: begin
                // whole byte read then one bit changed [RL5]
                case (st.op)
                    rmw_pkg::OP_SET:       next_st.data = bus_rdata | mask;
                    rmw_pkg::OP_CLEAR:     next_st.data = bus_rdata & ~mask;
                    rmw_pkg::OP_INVERT:    next_st.data = bus_rdata ^ mask;
                    rmw_pkg::OP_STORE:     next_st.data = st.carry ? (bus_rdata | mask)
                                                                   : (bus_rdata & ~mask);
                    rmw_pkg::OP_STORE_INV: next_st.data = st.carry ? (bus_rdata & ~mask)
                                                                   : (bus_rdata | mask);
                    default:               next_st.data = bus_rdata;
                endcase
                next_st.state = rmw_pkg::RMW_WRITE;
            end
            rmw_pkg::RMW_WRITE: begin
                next_st.done  = 1'b1;
                next_st.state = rmw_pkg::RMW_IDLE;
            end
            rmw_pkg::RMW_MREAD: begin
                if (st.cnt == 16'h0000) begin
                    next_st.done  = 1'b1;
                    next_st.state = rmw_pkg::RMW_IDLE;
                end else begin
                    next_st.data  = bus_rdata; // [RL3]
                    next_st.state = rmw_pkg::RMW_MWRIT;
                end
            end
            rmw_pkg::RMW_MWRIT: begin
                next_st.src   = st.src + 24'h00_0001; // [RL3]
                next_st.dst   = st.dst + 24'h00_0001; // [RL4]
                next_st.cnt   = st.cnt - 16'h0001;
                next_st.state = rmw_pkg::RMW_MREAD;
            end
            default:            next_st.state = rmw_pkg::RMW_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            st       <= '0;
            st.state <= rmw_pkg::RMW_IDLE;
            pin_out    <= 8'h00;
            pin_oe_out <= 8'h00;
            count_out  <= 8'h00;
        end else if (ce_in) begin
            st         <= next_st;
            pin_out    <= pin_q;
            pin_oe_out <= oe_q;
            count_out  <= cnt_q;
        end
    end

    assign busy_out               = (st.state != rmw_pkg::RMW_IDLE);
    assign done_out               = st.done;
    assign last_data_out          = st.data;
    assign source_pointer_reg_out = st.src;
    assign dest_pointer_reg_out   = st.dst;
    assign count_reg_out          = st.cnt;
endmodule
`default_nettype wire

/* dv/rmw_pins.sv */
// port five pin model for the rmw engine
`timescale 1ns/1ns
`default_nettype none
// ----
// pins
// ----
module rmw_pins (
    // from device
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_out,
    // outside world
    input  wire logic [7:0] ext_in,
    output logic      [7:0] level_out
);
    // driven bits show the latch, the rest the outside level
    assign level_out = (pin_oe_out & pin_out) | (~pin_oe_out & ext_in);
endmodule
`default_nettype wire

/* dv/rmw_properties.sv */
// bit op, port, block move and reset properties of the rmw engine
`timescale 1ns/1ns
`default_nettype none
module rmw_props (
    // clock and command
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    input  wire logic        start_in,
    input  wire logic [2:0]  op_in,
    input  wire logic [23:0] addr_in,
    input  wire logic [2:0]  bit_in,
    input  wire logic        carry_in,
    // status
    input  wire logic        busy_out,
    input  wire logic        done_out,
    input  wire logic [7:0]  last_data_out,
    input  wire logic [15:0] count_reg_out,
    input  wire logic [7:0]  pin_out,
    input  wire logic [7:0]  pin_oe_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);
    wire logic bit_op = start_in && !busy_out && op_in < 3'h5;
    wire logic fin = done_out && op_in < 3'h5;
    // ----
    // checks
    // ----
    chk_bitop_walk: assert property (
        bit_op |=> busy_out ##1 busy_out ##1 (done_out && !busy_out))
        else $error("bit op took wrong number of cycles");
    chk_set_bit: assert property (
        done_out && op_in == rmw_pkg::OP_SET |-> last_data_out[bit_in])
        else $error("set left target bit low");
    chk_store_bit: assert property (
        done_out && (op_in == rmw_pkg::OP_STORE || op_in == rmw_pkg::OP_STORE_INV)
        |-> last_data_out[bit_in] == (carry_in ^ (op_in == rmw_pkg::OP_STORE_INV)))
        else $error("store wrote wrong bit value");
    chk_dir_ones: assert property (
        done_out && addr_in == rmw_pkg::ADDR_PORT_DIR && op_in == rmw_pkg::OP_CLEAR
        |-> last_data_out == ~(8'h01 << bit_in))
        else $error("direction byte did not read as ones");
    chk_data_follow: assert property (
        fin && addr_in == rmw_pkg::ADDR_PORT_DATA |-> ##[0:2] pin_out == last_data_out)
        else $error("latch did not take written byte");
    chk_dir_follow: assert property (
        fin && addr_in == rmw_pkg::ADDR_PORT_DIR |-> ##[0:2] pin_oe_out == last_data_out)
        else $error("direction did not take written byte");
    chk_unmapped_keep: assert property (
        bit_op && addr_in[23:16] == 8'h80 |=> ($stable(pin_out) && $stable(pin_oe_out)) [*4])
        else $error("unmapped write changed port state");
    chk_move_count: assert property (
        done_out && op_in == rmw_pkg::OP_MOVE_BYTE |-> count_reg_out == 16'h0000)
        else $error("move ended with count left");
    chk_reset_idle: assert property (
        disable iff (1'b0) srst_in ##1 srst_in |=> !busy_out && !done_out && pin_oe_out == 8'h00)
        else $error("reset left engine active");
    cover property (bit_op && addr_in == rmw_pkg::ADDR_PORT_DATA);
    cover property (bit_op && addr_in == rmw_pkg::ADDR_TIMER);
    cover property (done_out && op_in == rmw_pkg::OP_MOVE_WORD);
endmodule
bind rmw_core rmw_props u_props (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .start_in(start_in), .op_in(op_in), .addr_in(addr_in), .bit_in(bit_in),
    .carry_in(carry_in), .busy_out(busy_out), .done_out(done_out),
    .last_data_out(last_data_out), .count_reg_out(count_reg_out),
    .pin_out(pin_out), .pin_oe_out(pin_oe_out));
`default_nettype wire

/* dv/rmw_core_test.sv */
// self-checking bench for the rmw engine
`timescale 1ns/1ns
`default_nettype none
module rmw_core_test;
    logic        clk = 0, srst = 1, start = 0, carry = 0, busy, done, c;
    logic [2:0]  op = 3'h7, bn = 3'h0, o, b;
    logic [23:0] addr = 0, src = 0, dst = 0, so, dso, a;
    logic [15:0] cnt = 0, co;
    logic [7:0]  ext = 0, lvl, pout, poe, last, tcnt, ml = 0, md = 0, rd, ex, e;
    int          err_count = 0, tests_run = 0, n;
    always #5 clk = ~clk;
    rmw_core u_dut (.core_clk_in(clk), .srst_in(srst), .ce_in(1'b1), .start_in(start),
        .op_in(op), .addr_in(addr), .bit_in(bn), .carry_in(carry),
        .source_pointer_reg_in(src), .dest_pointer_reg_in(dst), .count_reg_word_in(cnt),
        .busy_out(busy), .done_out(done), .last_data_out(last), .source_pointer_reg_out(so),
        .dest_pointer_reg_out(dso), .count_reg_out(co), .pin_in(lvl), .pin_out(pout),
        .pin_oe_out(poe), .count_out(tcnt));
    rmw_pins u_pins (.pin_out(pout), .pin_oe_out(poe), .ext_in(ext), .level_out(lvl));
    // ----
    // tasks
    // ----
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [2:0] ro, input logic [23:0] ra, input logic [2:0] rb,
                       input logic rc);
        @(posedge clk);
        op <= ro;
        addr <= ra;
        bn <= rb;
        carry <= rc;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
        end
        if (n >= 600) err_count++;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic [7:0] mod(input logic [2:0] fo, input logic [7:0] r,
                                       input logic [2:0] fb, input logic fc);
        mod = r & ~(8'h01 << fb);
        case (fo)
            rmw_pkg::OP_SET:    mod = r | (8'h01 << fb);
            rmw_pkg::OP_INVERT: mod = r ^ (8'h01 << fb);
            rmw_pkg::OP_CLEAR:  mod = mod;
            default:            mod[fb] = fc ^ (fo == rmw_pkg::OP_STORE_INV);
        endcase
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial begin
        void'($urandom(64));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        run(rmw_pkg::OP_CLEAR, rmw_pkg::ADDR_PORT_DIR, 3'h0, 1'b0);
        md = 8'hfe;
        chk(last, md);
        chk(poe, md);
        $display("test dir_clear end");
        for (int i = 0; i < 60; i++) begin
            e = 8'($urandom);
            o = 3'($urandom_range(4));
            b = 3'($urandom);
            c = 1'($urandom);
            a = ($urandom_range(3) == 0) ? rmw_pkg::ADDR_PORT_DIR : rmw_pkg::ADDR_PORT_DATA;
            ext <= e;
            rd = (a == rmw_pkg::ADDR_PORT_DIR) ? 8'hff : (md & ml) | (~md & e);
            ex = mod(o, rd, b, c);
            run(o, a, b, c);
            if (a == rmw_pkg::ADDR_PORT_DIR) md = ex;
            else ml = ex;
            chk(last, ex);
            chk(pout, ml);
            chk(poe, md);
        end
        $display("test random_bit_ops end");
        run(rmw_pkg::OP_INVERT, 24'h80_0000, 3'h2, 1'b0);
        chk(pout, ml);
        chk(poe, md);
        $display("test unmapped end");
        run(rmw_pkg::OP_SET, rmw_pkg::ADDR_TIMER, 3'h7, 1'b0);
        ex = 8'h80;
        chk(last, ex);
        n = 0;
        while (tcnt !== ex && n < 600) begin
            @(negedge clk);
            n++;
        end
        chk(tcnt, ex);
        $display("test timer_reload end");
        src <= rmw_pkg::ADDR_PORT_DIR;
        dst <= rmw_pkg::RAM_BASE;
        cnt <= 16'h0301;
        run(rmw_pkg::OP_MOVE_BYTE, 24'h0, 3'h0, 1'b0);
        chk(so, rmw_pkg::ADDR_PORT_DIR + 24'h1);
        chk(dso, rmw_pkg::RAM_BASE + 24'h1);
        chk(co, 24'h0);
        run(rmw_pkg::OP_CLEAR, rmw_pkg::RAM_BASE, 3'h3, 1'b0);
        chk(last, 8'hf7);
        src <= rmw_pkg::RAM_BASE;
        dst <= rmw_pkg::RAM_BASE + 24'h10;
        cnt <= 16'h0001;
        run(rmw_pkg::OP_MOVE_WORD, 24'h0, 3'h0, 1'b0);
        chk(dso, rmw_pkg::RAM_BASE + 24'h11);
        chk(co, 24'h0);
        run(rmw_pkg::OP_SET, rmw_pkg::RAM_BASE + 24'h10, 3'h3, 1'b0);
        chk(last, 8'hff);
        run(rmw_pkg::OP_NONE, 24'h0, 3'h0, 1'b0);
        chk(busy, 1'b0);
        chk(last, 8'hff);
        $display("test block_move end");
        stop_test();
    end
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
